// ===== rtl/dfs_consts.svh
/*
 Constants of the synthesizer control core: control word layout, register
 offsets and reset values. Assumes inclusion by rtl/dfs_pkg.sv and the core.
*/
// Behaviour
// - 24-bit accumulator advances by frequency register
// - 22-bit settings, two top bits zero
// - first word mode zero, second mode one
// - mode pin picks the frequency setting
// - FSK active when mode select bit clear
// - deviation weighted by four
// - modulation high adds four times deviation
// - settings kept through standby
// - acquisition pump only while unlocked
// - three-bit acquisition gain field
// - feedback divider 256 or 512
// - rising clock shifts data; strobe loads latch
// - 24-bit words MSB first, last 24 kept
`ifndef DFS_CONSTS_SVH
`define DFS_CONSTS_SVH
// control word layout
`define DFS_WORD_W 24
`define DFS_FW_W 22
`define DFS_FSKD_W 8
`define DFS_ADDR2_MSB 23
`define DFS_ADDR2_LSB 22
`define DFS_ADDR3_LSB 21
`define DFS_ADDR_A 2'h0
`define DFS_ADDR_B 2'h1
`define DFS_ADDR_C 3'h4
`define DFS_ADDR_D 3'h5
`define DFS_ADDR_E 3'h7
`define DFS_FW_MSB 21
`define DFS_DIV_BIT 17
`define DFS_MODSEL_BIT 16
`define DFS_AG_MSB 15
`define DFS_AG_LSB 13
`define DFS_PLL_BIT 12
`define DFS_VCO_BIT 11
`define DFS_PA_MSB 10
`define DFS_PA_LSB 9
`define DFS_FSKD_MSB 7
`define DFS_FSKD_LSB 0
`define DFS_E_PAYLOAD_MSB 20
`define DFS_WORD_RST 24'h000000
// pin vector positions
`define DFS_PIN_SCLK 0
`define DFS_PIN_SDATA 1
`define DFS_PIN_STROBE 2
`define DFS_PIN_MODE 3
`define DFS_PIN_TXD 4
`define DFS_PIN_LOCK 5
`define DFS_PIN_WAKE 6
`define DFS_PIN_N 7
// apb map
`define DFS_OFS_CTRL 8'h00
`define DFS_OFS_STATUS 8'h04
`define DFS_OFS_FREQ 8'h08
`define DFS_OFS_PHASE 8'h0C
`define DFS_OFS_WORD_C 8'h10
`define DFS_OFS_WORD_D 8'h14
`define DFS_CTRL_RUN_RST 1'b1
`define DFS_CTRL_RUN_BIT 0
`endif

// ===== rtl/dfs_pkg.sv
/*
 Types of the synthesizer control core.
 Assumes dfs_consts.svh is on the include path.
*/
`include "dfs_consts.svh"
package dfs_pkg;
  typedef logic [`DFS_WORD_W-1:0] dfs_word_t;
  // analog-side controls derived from the latches
  typedef struct packed {
    logic pll_en;
    logic osc_en;
    logic [1:0] pa_mode;
    logic div_512;
    logic [2:0] acq_gain;
    logic acq_pump_en;
    logic fsk_active;
    logic test_mode;
  } dfs_ctrl_s;
  // raw asynchronous pins
  typedef struct packed {
    logic tx_wake;
    logic lock_det;
    logic tx_data;
    logic mode_sel;
    logic strobe;
    logic sdata;
    logic sclk;
  } dfs_pins_s;
endpackage

// ===== rtl/dfs_synth_ctrl.sv
/*
 Synthesizer control core: three-wire loader, control latches, frequency
 register with two-level FSK, phase accumulator and an APB status slave.
 Assumes pclk is the reference clock; pins arrive asynchronously.
*/
// Added by the designer: the register offsets and the APB slave port.
`timescale 1ns/10ps
`include "dfs_consts.svh"
module dfs_synth_ctrl
  import dfs_pkg::*;
#(
  parameter int ACC_W = 24
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire dfs_pins_s pins,
  output logic [ACC_W-1:0] freq_reg_q,
  output logic [ACC_W-1:0] phase_q,
  output dfs_ctrl_s ctrl_q
);

  // ==========================================================
  // pin synchronisers
  logic [`DFS_PIN_N-1:0] pin_m_q;
  logic [`DFS_PIN_N-1:0] pin_s_q;
  logic [`DFS_PIN_N-1:0] pin_p_q;
  logic [`DFS_PIN_N-1:0] pin_m_d;
  logic [`DFS_PIN_N-1:0] pin_s_d;
  logic [`DFS_PIN_N-1:0] pin_p_d;

  always_comb begin
    pin_m_d = pin_m_q;
    pin_s_d = pin_s_q;
    pin_p_d = pin_p_q;
    if (ce) begin
      pin_m_d = pins;
      pin_s_d = pin_m_q;
      pin_p_d = pin_s_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_m_q <= '0;
      pin_s_q <= '0;
      pin_p_q <= '0;
    end else begin
      pin_m_q <= pin_m_d;
      pin_s_q <= pin_s_d;
      pin_p_q <= pin_p_d;
    end
  end

  logic sclk_rise;
  logic strobe_rise;
  logic sdata_s;
  logic mode_s;
  logic txd_s;
  logic lock_s;
  logic wake_s;

  assign sclk_rise = pin_s_q[`DFS_PIN_SCLK] & ~pin_p_q[`DFS_PIN_SCLK];
  assign strobe_rise = pin_s_q[`DFS_PIN_STROBE] & ~pin_p_q[`DFS_PIN_STROBE];
  assign sdata_s = pin_s_q[`DFS_PIN_SDATA];
  assign mode_s = pin_s_q[`DFS_PIN_MODE];
  assign txd_s = pin_s_q[`DFS_PIN_TXD];
  assign lock_s = pin_s_q[`DFS_PIN_LOCK];
  assign wake_s = pin_s_q[`DFS_PIN_WAKE];

  // ==========================================================
  // serial shift register
  dfs_word_t shift_q;
  dfs_word_t shift_d;

  always_comb begin
    shift_d = shift_q;
    if (ce && sclk_rise) begin
      // msb first; older leading bits fall off the top
      shift_d = {shift_q[`DFS_WORD_W-2:0], sdata_s};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift_q <= `DFS_WORD_RST;
    end else begin
      shift_q <= shift_d;
    end
  end

  // ==========================================================
  // control latches, only reset by presetn
  function automatic logic hit2(input dfs_word_t w, input logic [1:0] a);
    hit2 = (w[`DFS_ADDR2_MSB:`DFS_ADDR2_LSB] == a);
  endfunction

  function automatic logic hit3(input dfs_word_t w, input logic [2:0] a);
    hit3 = (w[`DFS_ADDR2_MSB:`DFS_ADDR3_LSB] == a);
  endfunction

  dfs_word_t word_a_q;
  dfs_word_t word_b_q;
  dfs_word_t word_c_q;
  dfs_word_t word_d_q;
  dfs_word_t word_a_d;
  dfs_word_t word_b_d;
  dfs_word_t word_c_d;
  dfs_word_t word_d_d;
  logic test_q;
  logic test_d;

  always_comb begin
    word_a_d = word_a_q;
    word_b_d = word_b_q;
    word_c_d = word_c_q;
    word_d_d = word_d_q;
    test_d = test_q;
    // latches change only on a strobe, standby leaves them alone
    if (ce && strobe_rise) begin
      if (hit2(shift_q, `DFS_ADDR_A)) begin
        word_a_d = shift_q;
      end else if (hit2(shift_q, `DFS_ADDR_B)) begin
        word_b_d = shift_q;
      end else if (hit3(shift_q, `DFS_ADDR_C)) begin
        word_c_d = shift_q;
      end else if (hit3(shift_q, `DFS_ADDR_D)) begin
        word_d_d = shift_q;
      end else if (hit3(shift_q, `DFS_ADDR_E)) begin
        // test latch: any payload bit enters test mode, all zero leaves
        test_d = |shift_q[`DFS_E_PAYLOAD_MSB:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      word_a_q <= `DFS_WORD_RST;
      word_b_q <= `DFS_WORD_RST;
      word_c_q <= `DFS_WORD_RST;
      word_d_q <= `DFS_WORD_RST;
      test_q <= 1'b0;
    end else begin
      word_a_q <= word_a_d;
      word_b_q <= word_b_d;
      word_c_q <= word_c_d;
      word_d_q <= word_d_d;
      test_q <= test_d;
    end
  end

  // ==========================================================
  // frequency register
  logic [`DFS_FW_W-1:0] freq_word_mode_zero;
  logic [`DFS_FW_W-1:0] freq_word_mode_one;
  logic [`DFS_FSKD_W-1:0] fsk_deviation_value;
  logic modulation_mode_select;
  logic [ACC_W-1:0] base_freq;
  logic [ACC_W-1:0] fsk_step;
  logic [ACC_W-1:0] freq_reg_d;

  assign freq_word_mode_zero = word_a_q[`DFS_FW_MSB:0];
  assign freq_word_mode_one = word_b_q[`DFS_FW_MSB:0];
  assign fsk_deviation_value = word_c_q[`DFS_FSKD_MSB:`DFS_FSKD_LSB];
  assign modulation_mode_select = word_c_q[`DFS_MODSEL_BIT];

  always_comb begin
    // two top bits forced to zero
    base_freq = mode_s ? ACC_W'(freq_word_mode_one) : ACC_W'(freq_word_mode_zero);
    // deviation sits above two zero lsbs
    fsk_step = ACC_W'({fsk_deviation_value, 2'h0});
    freq_reg_d = freq_reg_q;
    if (ce) begin
      if (!modulation_mode_select && txd_s) begin
        freq_reg_d = ACC_W'(base_freq + fsk_step);
      end else begin
        freq_reg_d = base_freq;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      freq_reg_q <= '0;
    end else begin
      freq_reg_q <= freq_reg_d;
    end
  end

  // ==========================================================
  // phase accumulator
  logic run_q;
  logic [ACC_W-1:0] phase_d;

  always_comb begin
    phase_d = phase_q;
    if (ce && run_q && wake_s) begin
      // carry out of the msb is dropped
      phase_d = ACC_W'(phase_q + freq_reg_q);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_q <= '0;
    end else begin
      phase_q <= phase_d;
    end
  end

  // ==========================================================
  // analog controls, mode pin selects word c or word d for pll, osc, pa and pump; gain and divider always from word c
  dfs_ctrl_s ctrl_d;
  dfs_word_t mode_word;

  always_comb begin
    mode_word = mode_s ? word_c_q : word_d_q;
    ctrl_d = ctrl_q;
    if (ce) begin
      ctrl_d.pll_en = mode_word[`DFS_PLL_BIT];
      ctrl_d.osc_en = mode_word[`DFS_VCO_BIT];
      ctrl_d.pa_mode = mode_word[`DFS_PA_MSB:`DFS_PA_LSB];
      ctrl_d.div_512 = word_c_q[`DFS_DIV_BIT];
      ctrl_d.acq_gain = word_c_q[`DFS_AG_MSB:`DFS_AG_LSB];
      ctrl_d.acq_pump_en = mode_word[`DFS_PLL_BIT] & ~lock_s;
      ctrl_d.fsk_active = ~modulation_mode_select;
      ctrl_d.test_mode = test_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= '0;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  // ==========================================================
  // apb slave, zero wait states
  logic [31:0] prdata_d;
  logic run_d;
  logic mapped;

  always_comb begin
    case (paddr)
      `DFS_OFS_CTRL, `DFS_OFS_STATUS, `DFS_OFS_FREQ,
      `DFS_OFS_PHASE, `DFS_OFS_WORD_C, `DFS_OFS_WORD_D: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  always_comb begin
    prdata_d = prdata;
    run_d = run_q;
    if (ce && psel && !penable && !pwrite) begin
      case (paddr)
        `DFS_OFS_CTRL: prdata_d = 32'(run_q);
        `DFS_OFS_STATUS: prdata_d = 32'({ctrl_q.test_mode, ctrl_q.acq_pump_en,
                                         ctrl_q.fsk_active, wake_s, lock_s, txd_s, mode_s});
        `DFS_OFS_FREQ: prdata_d = 32'(freq_reg_q);
        `DFS_OFS_PHASE: prdata_d = 32'(phase_q);
        `DFS_OFS_WORD_C: prdata_d = 32'(word_c_q);
        `DFS_OFS_WORD_D: prdata_d = 32'(word_d_q);
        default: prdata_d = 32'h00000000;
      endcase
    end
    if (ce && psel && penable && pwrite && paddr == `DFS_OFS_CTRL) begin
      run_d = pwdata[`DFS_CTRL_RUN_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      run_q <= `DFS_CTRL_RUN_RST;
    end else begin
      prdata <= prdata_d;
      run_q <= run_d;
    end
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_adv;
    ce && run_q && wake_s;
  endsequence

  property p_acc_step;
    s_adv |=> phase_q == ACC_W'($past(phase_q) + $past(freq_reg_q));
  endproperty
  a_acc_step: assert property (p_acc_step)
    else $error("accumulator did not advance by frequency register");

  property p_acc_hold;
    !ce |=> $stable(phase_q) && $stable(freq_reg_q);
  endproperty
  a_acc_hold: assert property (p_acc_hold)
    else $error("state moved while clock enable low");

  property p_top_zero;
    ce && (modulation_mode_select || !txd_s) |=> freq_reg_q[ACC_W-1:ACC_W-2] == 2'h0;
  endproperty
  a_top_zero: assert property (p_top_zero)
    else $error("frequency register top bits not zero");

  property p_mode_sel;
    ce && (modulation_mode_select || !txd_s) |=>
      freq_reg_q == ($past(mode_s) ? ACC_W'($past(word_b_q[`DFS_FW_MSB:0]))
                                   : ACC_W'($past(word_a_q[`DFS_FW_MSB:0])));
  endproperty
  a_mode_sel: assert property (p_mode_sel)
    else $error("frequency register not the selected word");

  property p_fsk_high;
    ce && !modulation_mode_select && txd_s |=>
      freq_reg_q == ACC_W'($past(base_freq) + 4 * $past(fsk_deviation_value));
  endproperty
  a_fsk_high: assert property (p_fsk_high)
    else $error("fsk high frequency wrong");

  property p_keep;
    !strobe_rise |=> $stable(word_a_q) && $stable(word_b_q) && $stable(word_c_q);
  endproperty
  a_keep: assert property (p_keep)
    else $error("setting changed without a strobe");

  property p_acq;
    ##1 ctrl_q.acq_pump_en |-> $past(!lock_s);
  endproperty
  a_acq: assert property (p_acq)
    else $error("acquisition pump on while locked");

  sequence s_load_c;
    ce && strobe_rise && hit3(shift_q, `DFS_ADDR_C);
  endsequence

  property p_gain;
    s_load_c ##1 ce |=> ctrl_q.acq_gain == $past(shift_q[`DFS_AG_MSB:`DFS_AG_LSB], 2)
      && ctrl_q.div_512 == $past(shift_q[`DFS_DIV_BIT], 2);
  endproperty
  a_gain: assert property (p_gain)
    else $error("gain or divider not loaded from word");

  property p_shift;
    ce && sclk_rise |=> shift_q == {$past(shift_q[`DFS_WORD_W-2:0]), $past(sdata_s)};
  endproperty
  a_shift: assert property (p_shift)
    else $error("serial bit not shifted in");

endmodule

// ===== verification/dfs_mcu_model.sv
/*
 Controller model: loads control words over the three-wire link.
 Assumes send is entered just after a rising pclk edge.
*/
`timescale 1ns/10ps
module dfs_mcu_model (
  input wire logic pclk,
  output logic sclk,
  output logic sdata,
  output logic strobe
);
  initial begin
    sclk = 1'b0;
    sdata = 1'b0;
    strobe = 1'b0;
  end
  // ==========
  // link clock 400 ns, still between frames; leading bits are junk
  task automatic send(input logic [25:0] v);
    for (int i = 25; i >= 0; i--) begin
      sdata <= v[i];
      repeat (4) @(posedge pclk);
      sclk <= 1'b1;
      repeat (4) @(posedge pclk);
      sclk <= 1'b0;
    end
    repeat (2) @(posedge pclk);
    sdata <= 1'b0;
    repeat (2) @(posedge pclk);
    strobe <= 1'b1;
    repeat (4) @(posedge pclk);
    strobe <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask
endmodule

// ===== verification/tb_dfs_synth_ctrl.sv
/*
 Self-checking bench of the synthesizer control core.
 Assumes the controller model and the design are compiled first.
*/
`timescale 1ns/10ps
`include "dfs_consts.svh"
module tb_dfs_synth_ctrl
  import dfs_pkg::*;
;
  logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic sclk, sdata, strobe, mode, txd, lock, wake;
  dfs_pins_s pins;
  logic [23:0] freq, phase;
  dfs_ctrl_s ctrl;
  int err_count, check_count;
  assign pins = {wake, lock, txd, mode, strobe, sdata, sclk};
  dfs_synth_ctrl dfs_synth_ctrl_inst (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pins(pins), .freq_reg_q(freq), .phase_q(phase),
    .ctrl_q(ctrl));
  dfs_mcu_model dfs_mcu_model_inst (.pclk(pclk), .sclk(sclk), .sdata(sdata), .strobe(strobe));
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  // ==========
  // helpers
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic er);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic load(input logic [23:0] w);
    logic [1:0] jk;
    jk = 2'($urandom);
    dfs_mcu_model_inst.send({jk, w});
  endtask
  task automatic settle();
    repeat (6) @(posedge pclk);
  endtask
  function automatic logic [23:0] exp_freq(input logic [21:0] fw, input logic [7:0] dv,
                                           input logic ms, input logic t);
    exp_freq = {2'h0, fw};
    if (!ms && t) exp_freq = exp_freq + {14'h0, dv, 2'h0};
  endfunction
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (50000) @(posedge pclk);
    err_count++;
    $display("ERROR watchdog expected done seen timeout");
    report_and_stop();
  end
  // ==========
  // tests
  initial begin
    logic [31:0] rd;
    logic er, ms, d5, osc, pll, ext;
    logic [21:0] fa, fb;
    logic [7:0] dv;
    logic [2:0] gn;
    logic [23:0] p0, p1, ef, wc;
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {mode, txd, lock} = '0;
    ce = 1'b1;
    wake = 1'b1;
    void'($urandom(79727));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `DFS_OFS_CTRL, 32'h0, rd, er);
    chk("ctrl reset", 32'h1, rd);
    apb(1'b0, 8'h18, 32'h0, rd, er);
    chk("unmapped err", 32'h1, {31'h0, er});
    chk("unmapped data", 32'h0, rd);
    $display("test apb done");
    for (int it = 0; it < 3; it++) begin
      fa = 22'($urandom);
      fb = (it == 0) ? 22'h3FFFFF : 22'($urandom);
      dv = (it == 0) ? 8'hFF : 8'($urandom);
      ms = (it == 2);
      {gn, d5, pll, ext} = 6'($urandom);
      osc = ~ext;
      load({2'h0, fa});
      load({2'h1, fb});
      wc = {3'h4, 3'h0, d5, ms, gn, pll, osc, 2'h1, 1'b0, dv};
      load(wc);
      load({3'h5, 8'h00, 1'b1, 1'b1, 2'h2, 9'h000});
      for (int k = 0; k < 4; k++) begin
        mode <= k[1];
        txd <= k[0];
        settle();
        chk("freq", {8'h0, exp_freq(k[1] ? fb : fa, dv, ms, k[0])}, {8'h0, freq});
      end
      chk("fsk", {31'h0, ~ms}, {31'h0, ctrl.fsk_active});
      chk("gain", {29'h0, gn}, {29'h0, ctrl.acq_gain});
      chk("div", {31'h0, d5}, {31'h0, ctrl.div_512});
      chk("osc", {31'h0, osc}, {31'h0, ctrl.osc_en});
      chk("pll", {31'h0, pll}, {31'h0, ctrl.pll_en});
      for (int k = 0; k < 2; k++) begin
        lock <= k[0];
        settle();
        chk("pump", {31'h0, pll & ~k[0]}, {31'h0, ctrl.acq_pump_en});
      end
      for (int k = 0; k < 8; k++) begin
        @(posedge pclk);
        p0 = phase;
        p1 = p0 + freq;
        @(posedge pclk);
        chk("phase step", {8'h0, p1}, {8'h0, phase});
      end
      ce <= 1'b0;
      @(posedge pclk);
      p0 = phase;
      settle();
      chk("ce frozen phase", {8'h0, p0}, {8'h0, phase});
      ce <= 1'b1;
      ef = exp_freq(fb, dv, ms, 1'b1);
      wake <= 1'b0;
      settle();
      p0 = phase;
      settle();
      chk("standby phase", {8'h0, p0}, {8'h0, phase});
      wake <= 1'b1;
      settle();
      chk("wake freq", {8'h0, ef}, {8'h0, freq});
      apb(1'b1, `DFS_OFS_CTRL, 32'h0, rd, er);
      settle();
      p0 = phase;
      apb(1'b0, `DFS_OFS_PHASE, 32'h0, rd, er);
      chk("halted phase", {8'h0, p0}, rd);
      apb(1'b1, `DFS_OFS_CTRL, 32'h1, rd, er);
      mode <= 1'b0;
      settle();
      chk("pa mode zero", 32'h2, {30'h0, ctrl.pa_mode});
      $display("test pass %0d done", it);
    end
    load({3'h6, 21'h1FFFFF});
    load({3'h7, 21'h000010});
    settle();
    chk("test mode on", 32'h1, {31'h0, ctrl.test_mode});
    apb(1'b0, `DFS_OFS_STATUS, 32'h0, rd, er);
    chk("status", {25'h0, 1'b1, ~lock, ~ms, wake, lock, txd, mode}, rd);
    chk("mapped err", 32'h0, {31'h0, er});
    apb(1'b0, `DFS_OFS_WORD_C, 32'h0, rd, er);
    chk("word c kept", {8'h0, wc}, rd);
    apb(1'b0, `DFS_OFS_WORD_D, 32'h0, rd, er);
    chk("word d", 32'h00A01C00, rd);
    apb(1'b0, `DFS_OFS_FREQ, 32'h0, rd, er);
    chk("freq read", {8'h0, exp_freq(fa, dv, ms, txd)}, rd);
    load(24'hE00000);
    settle();
    chk("test mode off", 32'h0, {31'h0, ctrl.test_mode});
    $display("test latches done");
    report_and_stop();
  end
endmodule
